// ### oau_top.sv
// Operand address unit: instruction field decode, shared address adder,
// storage select, pointers, channel counters, holding and write registers.
// Assumes storage answers mem_rdata by the last clock of a memory cycle.
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ps

module oau_top #(
  parameter int MEM_CYCLE_CLKS = oau_pkg::MEM_CYCLE_CLKS,
  parameter int NUM_CHAN = oau_pkg::NUM_CHAN
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core storage
  output oau_pkg::oau_mem_req_t mem_req,
  input wire logic [26:0] mem_rdata,
  // Execution control
  input wire logic exec_last,
  input wire logic exec_inc2,
  input wire logic exec_muldiv,
  input wire oau_pkg::oau_var_kind_t var_kind,
  output oau_pkg::oau_decode_t instr_dec,
  output oau_pkg::oau_var_route_t var_route,
  output logic field_select_word,
  output logic [4:0] field_size,
  output logic mem_cycle_end,
  // Channels
  input wire logic chan_grant,
  input wire logic [3:0] chan_sel,
  input wire logic chan_dir_wr,
  output logic [26:0] io_rdata,
  output logic io_rvalid,
  input wire logic wr_nib_valid,
  input wire logic [3:0] wr_nib,
  output logic wr_ready
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [$clog2(MEM_CYCLE_CLKS)-1:0] cyc_q;
  logic tick;
  oau_pkg::oau_state_t state_q;
  oau_pkg::oau_state_t state_d;
  oau_pkg::oau_acc_t acc_q;
  oau_pkg::oau_src_t src;
  logic run_q;
  logic [14:0] ilc_q;
  logic [14:0] ssr_q;
  logic [14:0] ptr_q;
  logic [14:0] xreg_q [oau_pkg::NUM_INDEX];
  logic [14:0] chan_cnt_q [NUM_CHAN];
  logic [26:0] chr_q;
  logic [26:0] wreg_q;
  logic [2:0] wcnt_q;
  logic wfull_q;
  logic [14:0] add_a;
  logic [14:0] add_b;
  logic add_sub;
  logic [14:0] sum;
  logic chan_win;
  logic cpu_turn;
  logic [26:0] cur_word;
  logic [3:0] cw_idx;
  logic wr_take;
  logic wr_issue;
  logic sw_wr;
  logic [31:0] rd_mux;
  logic rd_err;

  // Index register 0 is hardwired to zero so selector 0000 adds nothing
  function automatic logic [14:0] xval(input logic [3:0] sel);
    xval = (sel == 4'h0) ? 15'h0000 : xreg_q[sel];
  endfunction

  // ----------------------------------------------------------------
  // Memory cycle timing
  // ----------------------------------------------------------------
  // Free-running divider; all sequencing happens on the last clock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cyc_q <= '0;
    else if (tick)
      cyc_q <= '0;
    else
      cyc_q <= cyc_q + 1'b1;
  end

  assign tick = (cyc_q == ($clog2(MEM_CYCLE_CLKS))'(MEM_CYCLE_CLKS - 1));
  assign mem_cycle_end = tick;

  // ----------------------------------------------------------------
  // Adder source selection and sequencing
  // ----------------------------------------------------------------
  // Channels outrank the processor; the processor waits a cycle
  assign chan_win = tick && chan_grant && (chan_sel < 4'(NUM_CHAN));
  assign cpu_turn = tick && !chan_win && run_q;
  // Word read in this cycle if the processor owned it, else the held copy
  assign cur_word = (acc_q == oau_pkg::ACC_CPU) ? mem_rdata : chr_q;
  assign cw_idx = cur_word[oau_pkg::CW_IDX_LO +: 4];

  // One source feeds the adder per memory cycle
  always_comb
  begin
    src = oau_pkg::SRC_NONE;
    add_a = 15'h0000;
    add_b = 15'h0000;
    add_sub = 1'b0;
    state_d = state_q;
    if (chan_win)
    begin
      src = oau_pkg::SRC_CHAN;
      add_a = chan_cnt_q[chan_sel];
      add_b = 15'h0001;
    end
    else if (cpu_turn)
    begin
      case (state_q)
        oau_pkg::ST_IDLE:
        begin
          src = oau_pkg::SRC_ILC;
          add_a = ilc_q;
          state_d = oau_pkg::ST_FETCH;
        end
        oau_pkg::ST_FETCH:
        begin
          if (cur_word[oau_pkg::BIT_OPT])
          begin
            // Address field goes out unindexed to reach the control word
            src = oau_pkg::SRC_CW;
            add_a = {5'h00, cur_word[9:0]};
            state_d = oau_pkg::ST_CTRLW;
          end
          else
          begin
            src = oau_pkg::SRC_INDEX;
            add_a = {5'h00, cur_word[9:0]};
            add_b = xval(cur_word[oau_pkg::IDX_LO +: 4]);
            state_d = oau_pkg::ST_EXEC;
          end
        end
        oau_pkg::ST_CTRLW:
        begin
          // Both options take the operand address from the control word
          src = oau_pkg::SRC_INDEX;
          add_a = cur_word[14:0];
          add_b = xval(cw_idx);
          state_d = oau_pkg::ST_EXEC;
        end
        default:
        begin
          if (exec_last)
          begin
            src = oau_pkg::SRC_ILC;
            add_a = ilc_q;
            add_b = exec_inc2 ? 15'h0002 : 15'h0001;
            state_d = oau_pkg::ST_FETCH;
          end
          else
          begin
            src = oau_pkg::SRC_PTR;
            add_a = ptr_q;
            add_b = 15'h0001;
            add_sub = 1'b1;
          end
        end
      endcase
    end
    else if (tick && !run_q)
      state_d = oau_pkg::ST_IDLE;
  end

  // The shared adder wraps at 15 bits like the address space
  assign sum = add_sub ? (add_a - add_b) : (add_a + add_b);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= oau_pkg::ST_IDLE;
    else
      state_q <= state_d;
  end

  // ----------------------------------------------------------------
  // Address registers
  // ----------------------------------------------------------------
  // Storage select captures every adder result
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ssr_q <= 15'h0000;
    else if (src != oau_pkg::SRC_NONE)
      ssr_q <= sum;
  end

  // Instruction location counter; software may load it while stopped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ilc_q <= oau_pkg::ILC_RESET;
    else if (src == oau_pkg::SRC_ILC)
      ilc_q <= sum;
    else if (sw_wr && paddr == oau_pkg::OFF_ILC && !run_q)
      ilc_q <= pwdata[14:0];
  end

  // Operand pointer takes indexed sums and its own decrement
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ptr_q <= 15'h0000;
    else if (src == oau_pkg::SRC_INDEX || src == oau_pkg::SRC_PTR)
      ptr_q <= sum;
  end

  // Index registers are only written by software, never by indexing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < oau_pkg::NUM_INDEX; i++)
        xreg_q[i] <= 15'h0000;
    end
    else if (sw_wr && paddr[11:6] == oau_pkg::OFF_INDEX_BASE[11:6] && paddr[5:2] != 4'h0)
      xreg_q[paddr[5:2]] <= pwdata[14:0];
  end

  // Channel transfer counters; hardware update wins over software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NUM_CHAN; i++)
        chan_cnt_q[i] <= 15'h0000;
    end
    else if (src == oau_pkg::SRC_CHAN)
      chan_cnt_q[chan_sel] <= sum;
    else if (sw_wr && paddr[11:6] == oau_pkg::OFF_CHAN_BASE[11:6]
             && paddr[5:2] < 4'(NUM_CHAN))
      chan_cnt_q[paddr[5:2]] <= pwdata[14:0];
  end

  // ----------------------------------------------------------------
  // Storage access
  // ----------------------------------------------------------------
  // Owner of the access made in the coming memory cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      acc_q <= oau_pkg::ACC_NONE;
    else if (tick)
    begin
      if (chan_win)
        acc_q <= chan_dir_wr ? oau_pkg::ACC_CH_WR : oau_pkg::ACC_CH_RD;
      else if (src != oau_pkg::SRC_NONE)
        acc_q <= oau_pkg::ACC_CPU;
      else
        acc_q <= oau_pkg::ACC_NONE;
    end
  end

  // Strobes fire on the first clock of the cycle the address serves
  assign mem_req.rd = (cyc_q == '0)
                      && (acc_q == oau_pkg::ACC_CPU || acc_q == oau_pkg::ACC_CH_RD);
  assign wr_issue = (cyc_q == '0) && (acc_q == oau_pkg::ACC_CH_WR);
  assign mem_req.wr = wr_issue;
  assign mem_req.addr = ssr_q;
  assign mem_req.wdata = wreg_q;

  // Central holding register; a multiply or divide keeps its operand
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      chr_q <= 27'h0000000;
    else if (tick && acc_q == oau_pkg::ACC_CPU
             && !(state_q == oau_pkg::ST_EXEC && exec_muldiv))
      chr_q <= mem_rdata;
  end

  // Channel read data goes straight out, bypassing the holding register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      io_rdata <= 27'h0000000;
      io_rvalid <= 1'b0;
    end
    else
    begin
      io_rvalid <= tick && acc_q == oau_pkg::ACC_CH_RD;
      if (tick && acc_q == oau_pkg::ACC_CH_RD)
        io_rdata <= mem_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  // Fields latched as the instruction arrives, for the execution tables
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      instr_dec <= '0;
      var_route <= '0;
    end
    else if (cpu_turn && state_q == oau_pkg::ST_FETCH)
    begin
      instr_dec.opt <= cur_word[oau_pkg::BIT_OPT];
      instr_dec.idx_sel <= cur_word[oau_pkg::IDX_LO +: 4];
      instr_dec.opcode <= cur_word[oau_pkg::OP_LO +: 6];
      instr_dec.var_field <= cur_word[oau_pkg::VAR_LO +: 4];
      instr_dec.m_field <= cur_word[9:0];
      var_route <= '0;
      case (var_kind)
        oau_pkg::VK_ARITH: var_route.arith_register_select <= cur_word[oau_pkg::VAR_LO +: 4];
        oau_pkg::VK_INDEX: var_route.index_num <= cur_word[oau_pkg::VAR_LO +: 4];
        oau_pkg::VK_INDICATOR: var_route.indicator <= cur_word[oau_pkg::VAR_LO +: 4];
        default: var_route.channel <= cur_word[oau_pkg::VAR_LO +: 4];
      endcase
    end
  end

  // Control word format decides indirect versus field select
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      field_select_word <= 1'b0;
      field_size <= 5'h00;
    end
    else if (cpu_turn && state_q == oau_pkg::ST_FETCH)
      field_select_word <= 1'b0;
    else if (cpu_turn && state_q == oau_pkg::ST_CTRLW)
    begin
      field_select_word <= cur_word[oau_pkg::CW_FIELD_SELECT_WORD_BIT];
      field_size <= cur_word[oau_pkg::CW_SIZE_LO +: 5];
    end
  end

  // ----------------------------------------------------------------
  // Write register
  // ----------------------------------------------------------------
  // Nibbles shift in at the bottom; a full word stalls the source
  assign wr_take = wr_nib_valid && !wfull_q;
  assign wr_ready = !wfull_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wreg_q <= 27'h0000000;
      wcnt_q <= 3'h0;
      wfull_q <= 1'b0;
    end
    else if (wr_take)
    begin
      wreg_q <= {wreg_q[22:0], wr_nib};
      wcnt_q <= (wcnt_q == 3'(oau_pkg::NIB_PER_WORD - 1)) ? 3'h0 : wcnt_q + 3'h1;
      wfull_q <= (wcnt_q == 3'(oau_pkg::NIB_PER_WORD - 1));
    end
    else if (wr_issue)
      wfull_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign sw_wr = psel && penable && pwrite;
  assign pready = 1'b1;

  // Run control; stopping leaves the sequence idle at the next cycle end that no channel wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      run_q <= 1'b0;
    else if (sw_wr && paddr == oau_pkg::OFF_CTRL)
      run_q <= pwdata[oau_pkg::CTRL_RUN_BIT];
  end

  // Read decode; unmapped addresses read zero with an error
  always_comb
  begin
    rd_mux = 32'h00000000;
    rd_err = 1'b0;
    if (paddr == oau_pkg::OFF_CTRL)
      rd_mux = {31'h00000000, run_q};
    else if (paddr == oau_pkg::OFF_STATUS)
      rd_mux = {26'h0000000, acc_q, wfull_q, state_q};
    else if (paddr == oau_pkg::OFF_ILC)
      rd_mux = {17'h00000, ilc_q};
    else if (paddr == oau_pkg::OFF_SSR)
      rd_mux = {17'h00000, ssr_q};
    else if (paddr == oau_pkg::OFF_PTR)
      rd_mux = {17'h00000, ptr_q};
    else if (paddr == oau_pkg::OFF_CHR)
      rd_mux = {5'h00, chr_q};
    else if (paddr == oau_pkg::OFF_DECODE)
      rd_mux = {6'h00, field_select_word, field_size, instr_dec.opt, instr_dec.idx_sel,
                instr_dec.opcode, instr_dec.var_field, 5'h00};
    else if (paddr[11:6] == oau_pkg::OFF_INDEX_BASE[11:6] && paddr[1:0] == 2'h0)
      rd_mux = {17'h00000, xval(paddr[5:2])};
    else if (paddr[11:6] == oau_pkg::OFF_CHAN_BASE[11:6] && paddr[1:0] == 2'h0
             && paddr[5:2] < 4'(NUM_CHAN))
      rd_mux = {17'h00000, chan_cnt_q[paddr[5:2]]};
    else
      rd_err = 1'b1;
  end

  // Read data and error are registered in the setup phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata <= pwrite ? 32'h00000000 : rd_mux;
      pslverr <= rd_err;
    end
  end

endmodule

// ### oau_pkg.sv
// Constants, types and register map for the operand address unit.
// Assumes a 100 MHz pclk and one APB slave port; storage is outside.
package oau_pkg;

  // ----------------------------------------------------------------
  // Widths and timing
  // ----------------------------------------------------------------
  localparam int WORD_W = 27;
  localparam int ADDR_W = 15;
  localparam int M_W = 10;
  localparam int NIB_W = 4;
  localparam int NIB_PER_WORD = 7;
  localparam int NUM_CHAN = 13;
  localparam int NUM_INDEX = 16;
  localparam int CLK_PERIOD_NS = 10;
  localparam int MEM_CYCLE_NS = 4000;
  localparam int MEM_CYCLE_CLKS = MEM_CYCLE_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Field positions (bit n of the word is index n-1)
  // ----------------------------------------------------------------
  localparam int BIT_OPT = 24;
  localparam int IDX_LO = 20;
  localparam int OP_LO = 14;
  localparam int VAR_LO = 10;
  localparam int CW_FIELD_SELECT_WORD_BIT = 24;
  localparam int CW_SIZE_LO = 15;
  localparam int CW_IDX_LO = 20;

  // ----------------------------------------------------------------
  // Register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_ILC = 12'h008;
  localparam logic [11:0] OFF_SSR = 12'h00C;
  localparam logic [11:0] OFF_PTR = 12'h010;
  localparam logic [11:0] OFF_CHR = 12'h014;
  localparam logic [11:0] OFF_DECODE = 12'h018;
  localparam logic [11:0] OFF_INDEX_BASE = 12'h040;
  localparam logic [11:0] OFF_CHAN_BASE = 12'h080;
  localparam logic [14:0] ILC_RESET = 15'h0000;
  localparam int CTRL_RUN_BIT = 0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_CTRLW, ST_EXEC} oau_state_t;
  typedef enum logic [1:0] {ACC_NONE, ACC_CPU, ACC_CH_RD, ACC_CH_WR} oau_acc_t;
  typedef enum logic [2:0] {SRC_NONE, SRC_ILC, SRC_INDEX, SRC_CW, SRC_PTR,
                            SRC_CHAN} oau_src_t;
  typedef enum logic [1:0] {VK_ARITH, VK_INDEX, VK_INDICATOR, VK_CHANNEL} oau_var_kind_t;

  typedef struct packed {
    logic opt;
    logic [3:0] idx_sel;
    logic [5:0] opcode;
    logic [3:0] var_field;
    logic [9:0] m_field;
  } oau_decode_t;

  typedef struct packed {
    logic [3:0] arith_register_select;
    logic [3:0] index_num;
    logic [3:0] indicator;
    logic [3:0] channel;
  } oau_var_route_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [14:0] addr;
    logic [26:0] wdata;
  } oau_mem_req_t;

endpackage

// ### oau_top_properties.sv
// Concurrent checks on the operand address unit's ports.
// Assumes one pclk domain and the async active-low presetn.
`timescale 1ns/1ps

module oau_top_properties #(
  parameter int MEM_CYCLE_CLKS = 400
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Watched outputs
  input wire logic pready,
  input wire oau_pkg::oau_mem_req_t mem_req,
  input wire oau_pkg::oau_decode_t instr_dec,
  input wire logic field_select_word,
  input wire logic mem_cycle_end,
  input wire logic io_rvalid,
  input wire logic wr_ready
);
  int cnt_q;

  // Clocks since the last cycle end; restarts with reset as the unit's own count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= 0;
    else if (mem_cycle_end)
      cnt_q <= 0;
    else
      cnt_q <= cnt_q + 1;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Cycle framing and storage strobes
  chk_cycle_len: assert property (mem_cycle_end == (cnt_q == MEM_CYCLE_CLKS - 1))
    else $error("memory cycle length wrong");
  chk_strobe_start: assert property ((mem_req.rd || mem_req.wr) |-> $past(mem_cycle_end))
    else $error("strobe not on first clock of cycle");
  chk_one_access: assert property ((mem_req.rd || mem_req.wr) |=> !(mem_req.rd || mem_req.wr) [*3])
    else $error("second access in one cycle");
  chk_rd_wr_excl: assert property (!(mem_req.rd && mem_req.wr))
    else $error("read and write together");
  // Registers that may change only at a cycle end
  chk_addr_stands: assert property (!mem_cycle_end |=> $stable(mem_req.addr))
    else $error("address moved inside a cycle");
  chk_decode_stands: assert property (!mem_cycle_end |=> $stable(instr_dec))
    else $error("decode moved inside a cycle");
  chk_field_select_word_stands: assert property (!mem_cycle_end |=> $stable(field_select_word))
    else $error("field select moved inside a cycle");
  // Handshakes
  chk_pready_high: assert property (pready)
    else $error("pready low");
  chk_wreg_full: assert property (!wr_ready && !mem_req.wr |=> !wr_ready)
    else $error("write register emptied without a write");
  chk_io_rvalid: assert property (io_rvalid |-> $past(mem_cycle_end))
    else $error("channel data not after a cycle end");

  cover property (mem_req.rd);
  cover property (mem_req.wr);
  cover property (io_rvalid);
  cover property (field_select_word && mem_cycle_end);
endmodule

bind oau_top oau_top_properties #(.MEM_CYCLE_CLKS(MEM_CYCLE_CLKS)) u_props (.pclk, .presetn,
  .pready, .mem_req, .instr_dec, .field_select_word, .mem_cycle_end, .io_rvalid, .wr_ready);

// ### oau_core_store.sv
// Behavioural core storage facing the unit's storage port.
// Assumes one strobe per memory cycle; data must stand until the tick.
`timescale 1ns/1ps

module oau_core_store (
  // Clock and storage side
  input wire logic pclk,
  input wire oau_pkg::oau_mem_req_t mem_req,
  input wire logic mem_cycle_end,
  output logic [26:0] mem_rdata
);
  logic [26:0] mem [0:32767];

  // Empty storage so unwritten words read as zero
  initial
  begin
    mem_rdata = 27'h0;
    for (int i = 0; i < 32768; i++)
      mem[i] = 27'h0;
  end

  // After the tick the bus is released; inverting hides a stale word
  always @(posedge pclk)
  begin
    if (mem_req.rd)
      mem_rdata <= mem[mem_req.addr];
    else if (mem_cycle_end)
      mem_rdata <= ~mem_rdata;
    if (mem_req.wr)
      mem[mem_req.addr] <= mem_req.wdata;
  end
endmodule

// ### oau_top_tb.sv
// Self-checking bench: APB master, instruction runs, channel transfers.
// Assumes the storage model above and a shortened 32-clock memory cycle.
`timescale 1ns/1ps

module oau_top_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  oau_pkg::oau_mem_req_t mem_req;
  logic [26:0] mem_rdata, io_rdata;
  logic exec_last, exec_inc2, exec_muldiv, field_select_word, mem_cycle_end;
  logic chan_grant, chan_dir_wr, io_rvalid, wr_nib_valid, wr_ready;
  oau_pkg::oau_var_kind_t var_kind;
  oau_pkg::oau_decode_t instr_dec;
  oau_pkg::oau_var_route_t var_route;
  logic [4:0] field_size;
  logic [3:0] chan_sel, wr_nib;
  logic [14:0] xr [16];
  int mismatches, checked, cyc;

  oau_top #(.MEM_CYCLE_CLKS(32)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .mem_req, .mem_rdata, .exec_last, .exec_inc2,
    .exec_muldiv, .var_kind, .instr_dec, .var_route, .field_select_word, .field_size,
    .mem_cycle_end, .chan_grant, .chan_sel, .chan_dir_wr, .io_rdata, .io_rvalid,
    .wr_nib_valid, .wr_nib, .wr_ready);
  oau_core_store st (.pclk, .mem_req, .mem_cycle_end, .mem_rdata);

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Hang guard: far above the fewer than two thousand clocks the run needs
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      mismatches++;
      end_of_test();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  // One APB transfer; read data is taken at the edge that sees pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Wait as long as the slave asks; only the hang guard ends a stuck wait
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Returns just after the edge that ends a memory cycle
  task automatic tick();
    @(negedge pclk);
    while (mem_cycle_end !== 1'b1)
      @(negedge pclk);
    @(posedge pclk);
  endtask

  task automatic instr(input logic [14:0] a, input logic [26:0] w, input logic [26:0] cw,
                       input logic multi);
    logic [14:0] ea, nxt;
    logic [26:0] hold;
    logic [1:0] k;
    logic inc2;
    k = 2'(rnd());
    hold = w[24] ? cw : w;
    ea = w[24] ? cw[14:0] + xr[cw[23:20]] : 15'(w[9:0]) + xr[w[23:20]];
    // Step size drawn once so the expectation and the stimulus agree
    inc2 = seed[4];
    nxt = a + 15'h0001 + 15'(inc2);
    st.mem[a] = w;
    if (w[24])
      st.mem[15'(w[9:0])] = cw;
    st.mem[multi ? ea - 15'h0001 : ea] = 27'(rnd());
    var_kind <= oau_pkg::oau_var_kind_t'(k);
    apb(1'b1, oau_pkg::OFF_ILC, 32'(a));
    apb(1'b1, oau_pkg::OFF_CTRL, 32'h1);
    tick();
    apb(1'b0, oau_pkg::OFF_SSR, 32'h0);
    cmp("ssr_fetch", 32'(a), rd);
    tick();
    @(negedge pclk);
    cmp("instr_dec", 32'(w[24:0]), 32'(instr_dec));
    cmp("var_route", 32'(16'(w[13:10]) << (4 * (3 - k))), 32'(var_route));
    if (w[24])
    begin
      apb(1'b0, oau_pkg::OFF_SSR, 32'h0);
      cmp("ssr_cw", 32'(w[9:0]), rd);
      tick();
      @(negedge pclk);
      cmp("field_select_word", 32'({cw[24], cw[19:15]}), 32'({field_select_word, field_size}));
    end
    apb(1'b0, oau_pkg::OFF_SSR, 32'h0);
    cmp("ssr_ea", 32'(ea), rd);
    apb(1'b0, oau_pkg::OFF_PTR, 32'h0);
    cmp("ptr_ea", 32'(ea), rd);
    apb(1'b0, oau_pkg::OFF_CHR, 32'h0);
    cmp("chr_load", 32'(hold), rd);
    if (multi)
    begin
      exec_muldiv <= 1'b1;
      tick();
      exec_muldiv <= 1'b0;
      ea = ea - 15'h0001;
      apb(1'b0, oau_pkg::OFF_SSR, 32'h0);
      cmp("ssr_dec", 32'(ea), rd);
      apb(1'b0, oau_pkg::OFF_PTR, 32'h0);
      cmp("ptr_dec", 32'(ea), rd);
      apb(1'b0, oau_pkg::OFF_CHR, 32'h0);
      cmp("chr_kept", 32'(hold), rd);
    end
    exec_last <= 1'b1;
    exec_inc2 <= inc2;
    tick();
    exec_last <= 1'b0;
    apb(1'b0, oau_pkg::OFF_ILC, 32'h0);
    cmp("ilc_next", 32'(nxt), rd);
    apb(1'b0, oau_pkg::OFF_SSR, 32'h0);
    cmp("ssr_next", 32'(nxt), rd);
    apb(1'b0, oau_pkg::OFF_CHR, 32'h0);
    cmp("chr_operand", 32'(st.mem[ea]), rd);
    apb(1'b1, oau_pkg::OFF_ILC, 32'(~a));
    apb(1'b0, oau_pkg::OFF_ILC, 32'h0);
    cmp("ilc_locked", 32'(nxt), rd);
    apb(1'b1, oau_pkg::OFF_CTRL, 32'h0);
    tick();
  endtask

  task automatic chan(input logic [3:0] c, input logic dir);
    logic [14:0] v;
    logic [27:0] nb;
    v = 15'(rnd());
    nb = 28'(rnd());
    st.mem[v + 15'h0001] = 27'(rnd());
    apb(1'b1, oau_pkg::OFF_CHAN_BASE + 12'({c, 2'b00}), 32'(v));
    if (dir)
    begin
      for (int i = 0; i < 7; i++)
      begin
        wr_nib_valid <= 1'b1;
        wr_nib <= nb[27 - 4 * i -: 4];
        @(posedge pclk);
      end
      wr_nib_valid <= 1'b0;
      @(negedge pclk);
      cmp("wr_full", 32'h0, 32'(wr_ready));
    end
    chan_grant <= 1'b1;
    chan_sel <= c;
    chan_dir_wr <= dir;
    tick();
    chan_grant <= 1'b0;
    apb(1'b0, oau_pkg::OFF_CHAN_BASE + 12'({c, 2'b00}), 32'h0);
    cmp("chan_cnt", 32'(v + 15'h0001), rd);
    apb(1'b0, oau_pkg::OFF_SSR, 32'h0);
    cmp("ssr_chan", 32'(v + 15'h0001), rd);
    tick();
    @(negedge pclk);
    if (dir)
      cmp("wr_word", 32'(nb[26:0]), 32'(st.mem[v + 15'h0001]));
    else
      cmp("io_rdata", 32'({1'b1, st.mem[v + 15'h0001]}), 32'({io_rvalid, io_rdata}));
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Main sequence: reset values, index registers, instructions, channels
  initial
  begin
    logic [26:0] w, cw;
    {presetn, psel, penable, pwrite, exec_last, exec_inc2, exec_muldiv} = 7'h00;
    {chan_grant, chan_dir_wr, wr_nib_valid, paddr, pwdata, chan_sel, wr_nib} = 55'h0;
    var_kind = oau_pkg::VK_ARITH;
    seed = 32'd7096;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, oau_pkg::OFF_ILC, 32'h0);
    cmp("ilc_reset", 32'(oau_pkg::ILC_RESET), rd);
    apb(1'b0, 12'h0FC, 32'h0);
    cmp("unmapped", 32'h1, 32'(pslverr));
    apb(1'b1, oau_pkg::OFF_INDEX_BASE, 32'hFFFF);
    apb(1'b0, oau_pkg::OFF_INDEX_BASE, 32'h0);
    cmp("index0", 32'h0, rd);
    xr[0] = 15'h0000;
    for (int i = 1; i < 16; i++)
    begin
      xr[i] = (i == 15) ? 15'h7FFF : 15'(rnd());
      apb(1'b1, oau_pkg::OFF_INDEX_BASE + 12'(4 * i), 32'(xr[i]));
      apb(1'b0, oau_pkg::OFF_INDEX_BASE + 12'(4 * i), 32'h0);
      cmp("index_rb", 32'(xr[i]), rd);
    end
    for (int n = 0; n < 8; n++)
    begin
      w = 27'(rnd()) & 27'h0FFFFFF;
      cw = 27'(rnd()) & 27'h0FFFFFF;
      w[24] = (n == 1 || n == 2);
      cw[24] = (n == 1);
      if (n == 0)
        w[23:20] = 4'h0;
      if (n == 4)
        w[23:0] = 24'hF003FF;
      instr(15'(rnd()) | 15'h4000, w, cw, n == 3 || n == 5);
    end
    for (int n = 0; n < 6; n++)
      chan((n == 0) ? 4'hC : 4'(rnd() % 13), n[0]);
    end_of_test();
  end
endmodule
